// >>> hw/gcme_pkg.sv
// Purpose: shared constants and types for the gated counter mode engine
// Assumes: 16-bit counter channel, plain register port with 3-bit address
// Notes: register offsets and the gate-control codes are fixed here

package gcme_pkg;

   localparam int DATA_W = 16;
   localparam int ADDR_W = 3;

   // register offsets
   localparam logic [2:0] REG_MODE = 3'h0;
   localparam logic [2:0] REG_LOAD = 3'h1;
   localparam logic [2:0] REG_HOLD = 3'h2;
   localparam logic [2:0] REG_CMD = 3'h3;
   localparam logic [2:0] REG_COUNT = 3'h4;
   localparam logic [2:0] REG_STATUS = 3'h5;

   // gate_control_field encodings
   localparam logic [3:0] GATE_NONE = 4'h0;
   localparam logic [3:0] GATE_LEVEL = 4'h1;
   localparam logic [3:0] GATE_EDGE = 4'h2;

   // command register bit positions
   localparam int CMD_ARM_BIT = 0;
   localparam int CMD_DISARM_BIT = 1;
   localparam int CMD_LOAD_BIT = 2;
   localparam int CMD_RESET_BIT = 3;

   // reset values and the count step of one
   localparam logic [15:0] MODE_RESET = 16'h0000;
   localparam logic [15:0] LOAD_RESET = 16'h0000;
   localparam logic [15:0] HOLD_RESET = 16'h0000;
   localparam logic [15:0] COUNT_RESET = 16'h0000;
   localparam logic [15:0] COUNT_ONE = 16'h0001;

   typedef struct packed {
      logic [3:0] gate_control_field;
      logic [4:0] rsv_hi;
      logic special_gate_bit;
      logic reload_source_bit;
      logic repeat_select_bit;
      logic [2:0] rsv_lo;
      logic toggle_on_terminal_count;
   } gcme_mode_t;

   typedef struct packed {
      logic [10:0] rsv;
      logic out;
      logic terminal_count;
      logic second_phase;
      logic triggered;
      logic armed;
   } gcme_status_t;

   typedef enum logic {
      PHASE_FIRST,
      PHASE_SECOND
   } gcme_phase_t;

endpackage

// >>> hw/gcme_counter.sv
// Purpose: mode engine of one 16-bit counter channel with gating and reload
// Assumes: source and gate are synchronous to i_clock, active high
// Notes: one source edge per clock at most; edges found by a one-cycle delay

`timescale 1ns/1ns

module gcme_counter #(
   parameter int DATA_W = gcme_pkg::DATA_W,
   parameter int ADDR_W = gcme_pkg::ADDR_W
) (
   // clock, reset, enable
   input wire logic i_clock,
   input wire logic i_sys_rst,
   input wire logic i_clock_en,
   // register port
   input wire logic [ADDR_W-1:0] i_addr,
   input wire logic [DATA_W-1:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [DATA_W-1:0] o_rdata,
   // channel pins
   input wire logic i_source,
   input wire logic i_gate,
   output logic o_out
);

   gcme_pkg::gcme_mode_t mode;
   logic [DATA_W-1:0] load_reg;
   logic [DATA_W-1:0] hold_reg;
   logic [DATA_W-1:0] count;
   logic armed;
   logic triggered;
   logic tc_active;
   logic end_pending;
   logic out_tog;
   gcme_pkg::gcme_phase_t phase;
   logic src_prev;
   logic gate_prev;

   // register decode
   wire wr_mode = i_wr & (i_addr == gcme_pkg::REG_MODE);
   wire wr_load = i_wr & (i_addr == gcme_pkg::REG_LOAD);
   wire wr_hold = i_wr & (i_addr == gcme_pkg::REG_HOLD);
   wire wr_cmd = i_wr & (i_addr == gcme_pkg::REG_CMD);
   wire cmd_arm = wr_cmd & i_wdata[gcme_pkg::CMD_ARM_BIT];
   wire cmd_disarm = wr_cmd & i_wdata[gcme_pkg::CMD_DISARM_BIT];
   wire cmd_load = wr_cmd & i_wdata[gcme_pkg::CMD_LOAD_BIT];
   wire cmd_reset = wr_cmd & i_wdata[gcme_pkg::CMD_RESET_BIT];

   // pin edges
   wire src_edge = i_source & ~src_prev;
   wire gate_rise = i_gate & ~gate_prev;
   wire gate_fall = ~i_gate & gate_prev;

   // mode decode
   wire is_level =
      (mode.gate_control_field == gcme_pkg::GATE_LEVEL);
   wire is_edge =
      (mode.gate_control_field == gcme_pkg::GATE_EDGE);
   wire alt_reload = mode.reload_source_bit;
   wire repeat_on = mode.repeat_select_bit;
   wire release_disarm = mode.special_gate_bit & is_edge;

   // gate qualification: none passes all, level follows the pin,
   // edge follows the trigger latch so the pin is ignored once fired
   wire gate_ok = is_edge ? triggered :
                  is_level ? i_gate :
                  1'b1;

   // a counter in the terminal state always counts, whatever the gate
   wire count_edge = src_edge & (tc_active | (armed & gate_ok));
   wire hit_tc = count_edge & ~tc_active & (count == gcme_pkg::COUNT_ONE);
   wire leave_tc = count_edge & tc_active;

   wire first_phase = (phase == gcme_pkg::PHASE_FIRST);
   // the end of a count cycle is the only tc in Load-only modes, else
   // the second tc of the Hold-then-Load pair
   wire final_tc = ~alt_reload | ~first_phase;
   wire [DATA_W-1:0] reload_val =
      (alt_reload & first_phase) ? hold_reg :
      load_reg;

   // the end-of-cycle stop or disarm is deferred to the edge that leaves the terminal state
   wire stop_now = leave_tc & end_pending;
   wire auto_disarm = stop_now & ~repeat_on;
   wire edge_disarm = release_disarm & gate_fall & armed;
   wire disarm_any = cmd_disarm | cmd_reset | auto_disarm | edge_disarm;
   // only an armed counter can be triggered, and only once per cycle
   wire do_trigger =
      is_edge & gate_rise & armed & ~triggered;
   // repeating edge modes stay armed but wait for a new gate edge
   wire trig_clear = disarm_any | (stop_now & is_edge);

   // next values
   logic [DATA_W-1:0] next_count;
   logic next_armed;
   logic next_triggered;
   logic next_tc;
   logic next_end;
   logic next_tog;
   logic next_out;
   gcme_pkg::gcme_phase_t next_phase;

   always_comb begin
      next_count = count;
      if (cmd_reset | cmd_load) begin
         next_count = load_reg;
      end else if (hit_tc) begin
         next_count = reload_val;
      end else if (count_edge) begin
         // release disarm leaves count_edge low outside the terminal state, so the count holds
         next_count = count - gcme_pkg::COUNT_ONE;
      end
   end

   always_comb begin
      // an arm command wins over a disarm raised in the same cycle
      if (cmd_arm) begin
         next_armed = 1'b1;
      end else if (disarm_any) begin
         next_armed = 1'b0;
      end else begin
         next_armed = armed;
      end
   end

   always_comb begin
      if (trig_clear) begin
         next_triggered = 1'b0;
      end else if (do_trigger) begin
         next_triggered = 1'b1;
      end else begin
         next_triggered = triggered;
      end
   end

   always_comb begin
      next_phase = phase;
      if (cmd_reset | cmd_load) begin
         next_phase = gcme_pkg::PHASE_FIRST;
      end else if (hit_tc & alt_reload) begin
         unique case (phase)
            gcme_pkg::PHASE_FIRST: begin
               next_phase = gcme_pkg::PHASE_SECOND;
            end
            gcme_pkg::PHASE_SECOND: begin
               next_phase = gcme_pkg::PHASE_FIRST;
            end
         endcase
      end
   end

   always_comb begin
      next_tc = tc_active;
      next_end = end_pending;
      if (cmd_reset | cmd_load) begin
         next_tc = 1'b0;
         next_end = 1'b0;
      end else if (hit_tc) begin
         next_tc = 1'b1;
         next_end = final_tc;
      end else if (leave_tc) begin
         next_tc = 1'b0;
         next_end = 1'b0;
      end
   end

   // toggled output gives delay then pulse, or Load low and Hold high
   assign next_tog = cmd_reset ? 1'b0 :
                     hit_tc ? ~out_tog :
                     out_tog;
   assign next_out = mode.toggle_on_terminal_count ? next_tog :
                     next_tc;

   // read mux; unmapped offsets read as zero
   gcme_pkg::gcme_status_t status;
   assign status = '{
      rsv: 11'h000,
      out: o_out,
      terminal_count: tc_active,
      second_phase: ~first_phase,
      triggered: triggered,
      armed: armed
   };
   wire [DATA_W-1:0] rd_mux =
      (i_addr == gcme_pkg::REG_MODE) ? mode :
      (i_addr == gcme_pkg::REG_LOAD) ? load_reg :
      (i_addr == gcme_pkg::REG_HOLD) ? hold_reg :
      (i_addr == gcme_pkg::REG_COUNT) ? count :
      (i_addr == gcme_pkg::REG_STATUS) ? status :
      16'h0000;

   // software registers
   always_ff @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         mode <= gcme_pkg::MODE_RESET;
         load_reg <= gcme_pkg::LOAD_RESET;
         hold_reg <= gcme_pkg::HOLD_RESET;
      end else if (i_clock_en) begin
         if (wr_mode) begin
            mode <= i_wdata;
         end
         if (wr_load) begin
            load_reg <= i_wdata;
         end
         if (wr_hold) begin
            hold_reg <= i_wdata;
         end
      end
   end

   // read data valid only in the cycle after the strobe
   always_ff @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_rdata <= 16'h0000;
      end else if (i_clock_en) begin
         o_rdata <= i_rd ? rd_mux : 16'h0000;
      end
   end

   // counter state
   always_ff @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         count <= gcme_pkg::COUNT_RESET;
         armed <= 1'b0;
         triggered <= 1'b0;
         phase <= gcme_pkg::PHASE_FIRST;
      end else if (i_clock_en) begin
         count <= next_count;
         armed <= next_armed;
         triggered <= next_triggered;
         phase <= next_phase;
      end
   end

   // terminal state, output and edge history
   always_ff @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         tc_active <= 1'b0;
         end_pending <= 1'b0;
         out_tog <= 1'b0;
         o_out <= 1'b0;
         src_prev <= 1'b0;
         gate_prev <= 1'b0;
      end else if (i_clock_en) begin
         tc_active <= next_tc;
         end_pending <= next_end;
         out_tog <= next_tog;
         o_out <= next_out;
         src_prev <= i_source;
         gate_prev <= i_gate;
      end
   end

endmodule

// >>> dv/gcme_properties.sv
// Purpose: port-level properties of the counter mode engine
// Assumes: one clock domain, mode shadowed from bus writes
// Notes: the shadow only follows writes, so mode bits must read back whole
`timescale 1ns/1ns
module gcme_properties (
   // clock and reset
   input wire logic i_clock,
   input wire logic i_sys_rst,
   input wire logic i_clock_en,
   // register port
   input wire logic [2:0] i_addr,
   input wire logic [15:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic [15:0] o_rdata,
   // channel pins
   input wire logic i_source,
   input wire logic i_gate,
   input wire logic o_out
);
   gcme_pkg::gcme_mode_t mode;
   logic src_q;
   wire src_edge = i_source && !src_q;
   wire tog = mode.toggle_on_terminal_count;
   wire lvl = mode.gate_control_field == gcme_pkg::GATE_LEVEL;
   always_ff @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         mode <= gcme_pkg::MODE_RESET;
         src_q <= 1'b0;
      end else if (i_clock_en) begin
         // shadows freeze with the block so edges and modes stay aligned
         src_q <= i_source;
         if (i_wr && i_addr == gcme_pkg::REG_MODE) begin
            mode <= i_wdata;
         end
      end
   end
   default clocking @(posedge i_clock); endclocking
   default disable iff (i_sys_rst || !i_clock_en);
   out_cause_a: assert property (
      $changed(o_out) |-> $past(src_edge) || $past(i_wr))
      else $error("output moved without a source edge");
   pulse_hold_a: assert property (
      o_out && !tog && !src_edge && !i_wr |=> o_out)
      else $error("pulse output dropped early");
   level_pause_a: assert property (
      lvl && !i_gate && src_edge && !o_out && !tog && !i_wr |=> !o_out)
      else $error("edge counted with gate low");
   rdata_idle_a: assert property (
      !$past(i_rd) |-> o_rdata == 16'h0000)
      else $error("read data outside read slot");
   mode_read_a: assert property (
      $past(i_rd) && $past(i_addr) == gcme_pkg::REG_MODE
      |-> o_rdata == $past(mode))
      else $error("mode readback wrong");
   cmd_read_a: assert property (
      $past(i_rd) && $past(i_addr) == gcme_pkg::REG_CMD |-> o_rdata == 0)
      else $error("command read not zero");
   status_out_a: assert property (
      $past(i_rd) && $past(i_addr) == gcme_pkg::REG_STATUS
      |-> o_rdata[4] == $past(o_out) && o_rdata[15:5] == 0)
      else $error("status output bit wrong");
   unmapped_a: assert property (
      $past(i_rd) && $past(i_addr) > 3'h5 |-> o_rdata == 0)
      else $error("unmapped read not zero");
endmodule

// >>> dv/gcme_far_model.sv
// Purpose: far-side wiring that drives source and gate
// Assumes: source edges no closer than two clocks
// Notes: gap widens spacing to show slow sources
`timescale 1ns/1ns
module gcme_far_model (
   // clock
   input wire logic i_clock,
   // channel pins toward the counter
   output logic o_source,
   output logic o_gate
);
   initial begin
      o_source = 1'b0;
      o_gate = 1'b0;
   end
   task automatic pulse(input int n, input int gap);
      repeat (n) begin
         @(posedge i_clock) o_source <= 1'b1;
         @(posedge i_clock) o_source <= 1'b0;
         repeat (gap) @(posedge i_clock);
      end
   endtask
   task automatic set_gate(input logic g);
      @(posedge i_clock) o_gate <= g;
   endtask
endmodule

// >>> dv/gated_counter_mode_engine_test.sv
// Purpose: self-checking bench for the counter mode engine
// Assumes: clock enable dropped in one scenario only, with source pulses and a write while it is low
// Notes: counts and status read back over the register port
`timescale 1ns/1ns
module gated_counter_mode_engine_test;
   logic i_clock = 1'b0;
   logic i_sys_rst = 1'b1;
   logic [2:0] addr = 3'h0;
   logic [15:0] wdata = 16'h0000;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic clk_en = 1'b1;
   logic [15:0] rdata;
   logic src;
   logic gate;
   logic out;
   int error_cnt = 0;
   int compares = 0;
   int cycles = 0;
   always #10 i_clock = ~i_clock;
   gcme_counter dut_u (.i_clock(i_clock), .i_sys_rst(i_sys_rst),
      .i_clock_en(clk_en), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
      .i_rd(rd), .o_rdata(rdata), .i_source(src), .i_gate(gate),
      .o_out(out));
   gcme_far_model far_u (.i_clock(i_clock), .o_source(src), .o_gate(gate));
   task automatic final_report();
      $display("compares %0d error_cnt %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   always @(posedge i_clock) begin
      cycles++;
      if (cycles == 3000) begin
         error_cnt++;
         final_report();
      end
   end
   task automatic check(input string what, input logic [15:0] seen, e);
      compares++;
      if (seen !== e) begin
         error_cnt++;
         $display("unexpected %s expected %h seen %h", what, e, seen);
      end
   endtask
   task automatic wreg(input logic [2:0] a, input logic [15:0] d);
      @(posedge i_clock);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge i_clock);
      wr <= 1'b0;
   endtask
   task automatic rreg(input string w, input logic [2:0] a, logic [15:0] e);
      @(posedge i_clock);
      addr <= a;
      rd <= 1'b1;
      @(posedge i_clock);
      rd <= 1'b0;
      #1 check(w, rdata, e);
   endtask
   // mode, load, hold, then a load command and an arm
   task automatic setup(input logic [15:0] m, ld, hd);
      wreg(3'h0, m);
      wreg(3'h1, ld);
      wreg(3'h2, hd);
      wreg(3'h3, 16'h0004);
      wreg(3'h3, 16'h0001);
   endtask
   task automatic t_level();
      setup(16'h1000, 16'h0003, 16'h0000);
      rreg("mode", 3'h0, 16'h1000);
      far_u.pulse(2, 0);
      rreg("count", 3'h4, 16'h0003);
      far_u.set_gate(1'b1);
      far_u.pulse(3, 0);
      rreg("count", 3'h4, 16'h0003);
      rreg("status", 3'h5, 16'h0019);
      far_u.pulse(2, 0);
      rreg("count", 3'h4, 16'h0002);
      rreg("cmd", 3'h3, 16'h0000);
      rreg("unmapped", 3'h6, 16'h0000);
      $display("done level strobe");
   endtask
   task automatic t_edge();
      far_u.set_gate(1'b0);
      wreg(3'h0, 16'h2000);
      wreg(3'h1, 16'h0002);
      wreg(3'h3, 16'h0004);
      far_u.set_gate(1'b1);
      far_u.set_gate(1'b0);
      wreg(3'h3, 16'h0001);
      far_u.pulse(1, 0);
      rreg("count", 3'h4, 16'h0002);
      far_u.set_gate(1'b1);
      far_u.set_gate(1'b0);
      rreg("status", 3'h5, 16'h0003);
      far_u.pulse(2, 1);
      check("out", {15'h0000, out}, 16'h0001);
      far_u.pulse(2, 0);
      rreg("count", 3'h4, 16'h0001);
      $display("done edge strobe");
   endtask
   task automatic t_duty();
      setup(16'h0031, 16'h0002, 16'h0003);
      far_u.pulse(2, 2);
      rreg("count", 3'h4, 16'h0003);
      rreg("status", 3'h5, 16'h001D);
      far_u.pulse(3, 1);
      rreg("count", 3'h4, 16'h0002);
      check("out", {15'h0000, out}, 16'h0000);
      far_u.pulse(2, 0);
      rreg("count", 3'h4, 16'h0003);
      wreg(3'h3, 16'h0002);
      $display("done duty generator");
   endtask
   task automatic t_release();
      setup(16'h2040, 16'h0005, 16'h0000);
      far_u.set_gate(1'b1);
      far_u.pulse(2, 0);
      far_u.set_gate(1'b0);
      rreg("status", 3'h5, 16'h0000);
      far_u.pulse(2, 0);
      rreg("count", 3'h4, 16'h0003);
      wreg(3'h3, 16'h0004);
      rreg("count", 3'h4, 16'h0005);
      $display("done release disarm");
   endtask
   task automatic t_oneshot();
      setup(16'h2010, 16'h0002, 16'h0000);
      far_u.set_gate(1'b1);
      far_u.set_gate(1'b0);
      far_u.pulse(3, 0);
      rreg("status", 3'h5, 16'h0001);
      far_u.pulse(1, 0);
      rreg("count", 3'h4, 16'h0001);
      far_u.set_gate(1'b1);
      far_u.set_gate(1'b0);
      far_u.pulse(1, 0);
      rreg("count", 3'h4, 16'h0002);
      far_u.set_gate(1'b1);
      wreg(3'h0, 16'h2050);
      far_u.set_gate(1'b0);
      rreg("status", 3'h5, 16'h0018);
      $display("done one-shot");
   endtask
   task automatic t_soft();
      wreg(3'h3, 16'h0008);
      setup(16'h0021, 16'h0002, 16'h0002);
      // one idle edge after the pulse so the output has settled
      far_u.pulse(2, 1);
      check("out", {15'h0000, out}, 16'h0001);
      rreg("status", 3'h5, 16'h001D);
      far_u.pulse(4, 0);
      rreg("status", 3'h5, 16'h0000);
      rreg("count", 3'h4, 16'h0001);
      $display("done delayed pulse");
   endtask
   task automatic t_freeze();
      wreg(3'h3, 16'h0001);
      @(posedge i_clock);
      clk_en <= 1'b0;
      // two source edges and a write while frozen must all be lost
      far_u.pulse(2, 0);
      wreg(3'h1, 16'h0007);
      @(posedge i_clock);
      clk_en <= 1'b1;
      rreg("load", 3'h1, 16'h0002);
      rreg("count", 3'h4, 16'h0001);
      far_u.pulse(1, 1);
      rreg("count", 3'h4, 16'h0002);
      $display("done clock enable");
   endtask
   initial begin
      repeat (3) @(posedge i_clock);
      i_sys_rst <= 1'b0;
      t_level();
      t_edge();
      t_duty();
      t_release();
      t_oneshot();
      t_soft();
      t_freeze();
      final_report();
   end
endmodule
bind gcme_counter gcme_properties chk_u (.i_clock(i_clock),
   .i_sys_rst(i_sys_rst), .i_clock_en(i_clock_en), .i_addr(i_addr),
   .i_wdata(i_wdata),
   .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_source(i_source),
   .i_gate(i_gate), .o_out(o_out));
